// >>> verilog/phy_rx_enable_training.sv
`timescale 1ns/1ps
// Overview of operation
// - load command fields, send, hardware clears send
// - training bit set lets engine adjust delays
// - gap counter halts engine between dqs streams
// - self refresh frequency change handshake sequence
module phy_rx_enable_training
#(
   parameter int LANES = rx_train_pkg::LANES_DEF
)
(
   // clock, reset, enable
   input  wire logic                            core_clk_in,
   input  wire logic                            rst_n_in,
   input  wire logic                            clk_en_in,
   // memory clock from the phy, sampled
   input  wire logic                            memory_clock_in,
   // controller configuration bits
   input  wire logic                            refresh_suppress_in,
   input  wire logic [1:0]                      zq_short_period_in,
   input  wire logic                            train_target_dimm_in,
   input  wire logic                            train_nibble_select_in,
   input  wire logic                            rx_enable_train_go_in,
   // mode register command
   input  wire rx_train_pkg::mode_cmd_s         modecmd_in,
   input  wire logic                            modecmd_send_in,
   output logic                                 modecmd_send_out,
   output logic                                 modecmd_valid_out,
   output rx_train_pkg::mode_cmd_s              modecmd_out,
   // phase recovery seeds and results
   input  wire logic                            seed_load_in,
   input  wire rx_train_pkg::lane_delay_s [LANES-1:0] seed_in,
   input  wire logic [LANES-1:0]                dqs_strobe_in,
   input  wire logic [LANES-1:0]                dqs_late_in,
   output rx_train_pkg::lane_delay_s [LANES-1:0] recovered_delay_out,
   // self refresh and frequency change
   input  wire logic                            self_refresh_entry_req_in,
   input  wire logic                            self_refresh_exit_req_in,
   input  wire logic                            memory_clock_freq_valid_in,
   input  wire logic [rx_train_pkg::FREQ_W-1:0] memory_clock_freq_select_in,
   output logic                                 self_refresh_entry_req_out,
   output logic                                 self_refresh_exit_req_out,
   output logic                                 self_refresh_active_out,
   output logic                                 freq_change_pending_out,
   output logic [rx_train_pkg::FREQ_W-1:0]      memory_clock_freq_out,
   // status to the controller
   output logic                                 auto_refresh_enable_out,
   output logic                                 zq_short_enable_out,
   output logic                                 train_active_out,
   output logic                                 train_target_dimm_out,
   output logic                                 train_nibble_select_out
);

   // ----------------------------------------------------------------------
   // parameter check
   // ----------------------------------------------------------------------
   generate
      if (LANES < 1 || LANES > 18)
      begin : g_bad_lanes
         $error("LANES must be 1 to 18");
      end
   endgenerate

   // ----------------------------------------------------------------------
   // memory clock sampling
   // ----------------------------------------------------------------------
   logic mclk_s1_reg;
   logic mclk_s2_reg;
   logic mclk_s3_reg;
   logic mclk_stable_reg;
   logic memory_clock_rise;

   // three stages, a level counts once second and third agree
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         mclk_s1_reg     <= 1'b0;
         mclk_s2_reg     <= 1'b0;
         mclk_s3_reg     <= 1'b0;
         mclk_stable_reg <= 1'b0;
      end
      else if (clk_en_in)
      begin
         mclk_s1_reg <= memory_clock_in;
         mclk_s2_reg <= mclk_s1_reg;
         mclk_s3_reg <= mclk_s2_reg;
         if (mclk_s2_reg == mclk_s3_reg)
            mclk_stable_reg <= mclk_s3_reg;
      end
   end

   assign memory_clock_rise = (mclk_s2_reg == mclk_s3_reg) && mclk_s3_reg && !mclk_stable_reg;

   // ----------------------------------------------------------------------
   // configuration mirrors
   // ----------------------------------------------------------------------
   // refresh and zq gating, training selects
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         auto_refresh_enable_out <= 1'b1;
         zq_short_enable_out     <= 1'b1;
         train_active_out        <= 1'b0;
         train_target_dimm_out   <= 1'b0;
         train_nibble_select_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         auto_refresh_enable_out <= !refresh_suppress_in;
         zq_short_enable_out     <= (zq_short_period_in != 2'h0);
         train_active_out        <= rx_enable_train_go_in;
         train_target_dimm_out   <= train_target_dimm_in;
         train_nibble_select_out <= train_nibble_select_in;
      end
   end

   // ----------------------------------------------------------------------
   // mode register command
   // ----------------------------------------------------------------------
   rx_train_pkg::modecmd_state_e mc_state_reg;

   // latch on send, drive for one memory clock, then clear send
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         mc_state_reg      <= rx_train_pkg::MC_IDLE;
         modecmd_send_out  <= 1'b0;
         modecmd_valid_out <= 1'b0;
         modecmd_out       <= '0;
      end
      else if (clk_en_in)
      begin
         case (mc_state_reg)
            rx_train_pkg::MC_IDLE:
            begin
               if (modecmd_send_in)
               begin
                  modecmd_out      <= modecmd_in;
                  modecmd_send_out <= 1'b1;
                  mc_state_reg     <= rx_train_pkg::MC_WAIT;
               end
            end
            rx_train_pkg::MC_WAIT:
            begin
               if (memory_clock_rise)
               begin
                  modecmd_valid_out <= 1'b1;
                  mc_state_reg      <= rx_train_pkg::MC_DRIVE;
               end
            end
            rx_train_pkg::MC_DRIVE:
            begin
               if (memory_clock_rise)
               begin
                  modecmd_valid_out <= 1'b0;
                  modecmd_send_out  <= 1'b0;
                  mc_state_reg      <= rx_train_pkg::MC_IDLE;
               end
            end
            default:
            begin
               modecmd_valid_out <= 1'b0;
               modecmd_send_out  <= 1'b0;
               mc_state_reg      <= rx_train_pkg::MC_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // self refresh sequencing
   // ----------------------------------------------------------------------
   rx_train_pkg::selfref_state_e         sr_state_reg;
   logic [rx_train_pkg::MEMORY_CLOCK_CNT_W-1:0] sr_cnt_reg;

   localparam logic [rx_train_pkg::MEMORY_CLOCK_CNT_W-1:0] SR_ENTRY_LAST =
      rx_train_pkg::MEMORY_CLOCK_CNT_W'(rx_train_pkg::SR_ENTRY_MEMCLKS - 1);
   localparam logic [rx_train_pkg::MEMORY_CLOCK_CNT_W-1:0] SR_EXIT_LAST =
      rx_train_pkg::MEMORY_CLOCK_CNT_W'(rx_train_pkg::SR_EXIT_MEMCLKS - 1);

   // entry and exit requests stand until the dram has switched
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         sr_state_reg               <= rx_train_pkg::SR_RUN;
         sr_cnt_reg                 <= '0;
         self_refresh_entry_req_out <= 1'b0;
         self_refresh_exit_req_out  <= 1'b0;
         self_refresh_active_out    <= 1'b0;
      end
      else if (clk_en_in)
      begin
         case (sr_state_reg)
            rx_train_pkg::SR_RUN:
            begin
               if (self_refresh_entry_req_in)
               begin
                  self_refresh_entry_req_out <= 1'b1;
                  sr_cnt_reg                 <= '0;
                  sr_state_reg               <= rx_train_pkg::SR_ENTER;
               end
            end
            rx_train_pkg::SR_ENTER:
            begin
               if (memory_clock_rise)
               begin
                  if (sr_cnt_reg == SR_ENTRY_LAST)
                  begin
                     self_refresh_entry_req_out <= 1'b0;
                     self_refresh_active_out    <= 1'b1;
                     sr_state_reg               <= rx_train_pkg::SR_HELD;
                  end
                  else
                     sr_cnt_reg <= sr_cnt_reg + 1'b1;
               end
            end
            rx_train_pkg::SR_HELD:
            begin
               if (self_refresh_exit_req_in && !freq_change_pending_out)
               begin
                  self_refresh_exit_req_out <= 1'b1;
                  sr_cnt_reg                <= '0;
                  sr_state_reg              <= rx_train_pkg::SR_EXIT;
               end
            end
            rx_train_pkg::SR_EXIT:
            begin
               if (memory_clock_rise)
               begin
                  if (sr_cnt_reg == SR_EXIT_LAST)
                  begin
                     self_refresh_exit_req_out <= 1'b0;
                     self_refresh_active_out   <= 1'b0;
                     sr_state_reg              <= rx_train_pkg::SR_RUN;
                  end
                  else
                     sr_cnt_reg <= sr_cnt_reg + 1'b1;
               end
            end
            default:
            begin
               self_refresh_entry_req_out <= 1'b0;
               self_refresh_exit_req_out  <= 1'b0;
               self_refresh_active_out    <= 1'b0;
               sr_state_reg               <= rx_train_pkg::SR_RUN;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // frequency change
   // ----------------------------------------------------------------------
   logic                                freq_valid_d_reg;
   logic [rx_train_pkg::LOCK_CNT_W-1:0] lock_cnt_reg;

   localparam logic [rx_train_pkg::LOCK_CNT_W-1:0] LOCK_LAST =
      rx_train_pkg::LOCK_CNT_W'(rx_train_pkg::FREQ_LOCK_CYC - 1);

   // rising valid applies the new select and starts the relock wait
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         freq_valid_d_reg        <= 1'b0;
         lock_cnt_reg            <= '0;
         freq_change_pending_out <= 1'b0;
         memory_clock_freq_out   <= rx_train_pkg::FREQ_RST;
      end
      else if (clk_en_in)
      begin
         freq_valid_d_reg <= memory_clock_freq_valid_in;
         if (memory_clock_freq_valid_in && !freq_valid_d_reg && !freq_change_pending_out)
         begin
            memory_clock_freq_out   <= memory_clock_freq_select_in;
            freq_change_pending_out <= 1'b1;
            lock_cnt_reg            <= '0;
         end
         else if (freq_change_pending_out)
         begin
            if (lock_cnt_reg == LOCK_LAST)
               freq_change_pending_out <= 1'b0;
            else
               lock_cnt_reg <= lock_cnt_reg + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // phase recovery engines, one per byte lane
   // ----------------------------------------------------------------------
   generate
      for (genvar g = 0; g < LANES; g++)
      begin : g_lane
         phase_recovery_lane u_lane
         (
            .core_clk_in    (core_clk_in),
            .rst_n_in       (rst_n_in),
            .clk_en_in      (clk_en_in),
            .memory_clock_rise_in (memory_clock_rise),
            .train_go_in    (rx_enable_train_go_in),
            .seed_load_in   (seed_load_in),
            .seed_in        (seed_in[g]),
            .dqs_strobe_in  (dqs_strobe_in[g]),
            .dqs_late_in    (dqs_late_in[g]),
            .delay_out      (recovered_delay_out[g])
         );
      end
   endgenerate

endmodule // phy_rx_enable_training

// >>> verilog/rx_train_pkg.sv
package rx_train_pkg;

   // ----------------------------------------------------------------------
   // field widths
   // ----------------------------------------------------------------------
   localparam int GROSS_W        = 3;   // phase recovery gross field
   localparam int FINE_W         = 5;   // phase recovery fine field
   localparam int TOTAL_W        = GROSS_W + FINE_W;
   localparam int CS_W           = 3;   // mode command chip select
   localparam int BANK_W         = 3;   // mode command bank
   localparam int ADDR_W         = 16;  // mode command address
   localparam int FREQ_W         = 3;   // memory clock frequency select
   localparam int LANES_DEF      = 9;   // byte lanes incl. ecc lane

   // ----------------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------------
   localparam logic [GROSS_W-1:0] GROSS_RST = 3'h2;
   localparam logic [FINE_W-1:0]  FINE_RST  = 5'h00;
   localparam logic [FREQ_W-1:0]  FREQ_RST  = 3'h0;

   // ----------------------------------------------------------------------
   // timing counts
   // ----------------------------------------------------------------------
   localparam int CORE_MHZ        = 40;
   localparam int IDLE_MEMCLKS    = 8;    // gap that ends a dqs stream
   localparam int WARMUP_EDGES    = 4;    // edges before engine adjusts
   localparam int CNT_W           = 4;    // width of lane counters
   localparam int SR_ENTRY_MEMCLKS = 4;   // self refresh entry latency
   localparam int SR_EXIT_MEMCLKS  = 4;   // self refresh exit latency
   localparam int MEMORY_CLOCK_CNT_W    = 3;
   localparam int FREQ_LOCK_NS    = 1000; // clock relock time
   localparam int FREQ_LOCK_CYC   = (FREQ_LOCK_NS * CORE_MHZ + 999) / 1000;
   localparam int LOCK_CNT_W      = 6;

   // ----------------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [GROSS_W-1:0] gross;
      logic [FINE_W-1:0]  fine;
   } lane_delay_s;

   typedef struct packed {
      logic [CS_W-1:0]   chip_select;
      logic [BANK_W-1:0] bank;
      logic [ADDR_W-1:0] address;
   } mode_cmd_s;

   // ----------------------------------------------------------------------
   // state encodings (gray along the self refresh path; mode command drive to idle flips two bits)
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      MC_IDLE  = 2'h0,
      MC_WAIT  = 2'h1,
      MC_DRIVE = 2'h3
   } modecmd_state_e;

   typedef enum logic [1:0] {
      SR_RUN   = 2'h0,
      SR_ENTER = 2'h1,
      SR_HELD  = 2'h3,
      SR_EXIT  = 2'h2
   } selfref_state_e;

endpackage

// >>> verilog/phase_recovery_lane.sv
`timescale 1ns/1ps
module phase_recovery_lane
(
   // clock, reset, enable
   input  wire logic                     core_clk_in,
   input  wire logic                     rst_n_in,
   input  wire logic                     clk_en_in,
   // control from top
   input  wire logic                     memory_clock_rise_in,
   input  wire logic                     train_go_in,
   input  wire logic                     seed_load_in,
   input  wire rx_train_pkg::lane_delay_s seed_in,
   // lane pins
   input  wire logic                     dqs_strobe_in,
   input  wire logic                     dqs_late_in,
   // recovered delay
   output rx_train_pkg::lane_delay_s     delay_out
);

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   logic [1:0] sync1_reg;
   logic [1:0] sync2_reg;
   logic [1:0] sync3_reg;
   logic [1:0] pin_stable_reg;

   // three stages, second and third must agree
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         sync1_reg      <= 2'h0;
         sync2_reg      <= 2'h0;
         sync3_reg      <= 2'h0;
         pin_stable_reg <= 2'h0;
      end
      else if (clk_en_in)
      begin
         sync1_reg <= {dqs_late_in, dqs_strobe_in};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         for (int i = 0; i < 2; i++)
            if (sync2_reg[i] == sync3_reg[i])
               pin_stable_reg[i] <= sync3_reg[i];
      end
   end

   // ----------------------------------------------------------------------
   // stream gap counter
   // ----------------------------------------------------------------------
   logic [rx_train_pkg::CNT_W-1:0] idle_cnt_reg;
   logic [rx_train_pkg::CNT_W-1:0] stream_cnt_reg;
   logic                           engine_run;

   localparam logic [rx_train_pkg::CNT_W-1:0] IDLE_MAX = rx_train_pkg::CNT_W'(rx_train_pkg::IDLE_MEMCLKS);
   localparam logic [rx_train_pkg::CNT_W-1:0] WARM_MAX = rx_train_pkg::CNT_W'(rx_train_pkg::WARMUP_EDGES);

   // a long gap clears the stream count and halts the engine
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         idle_cnt_reg   <= '0;
         stream_cnt_reg <= '0;
      end
      else if (clk_en_in && memory_clock_rise_in)
      begin
         if (pin_stable_reg[0])
         begin
            idle_cnt_reg <= '0;
            if (stream_cnt_reg != WARM_MAX)
               stream_cnt_reg <= stream_cnt_reg + 1'b1;
         end
         else
         begin
            if (idle_cnt_reg != IDLE_MAX)
               idle_cnt_reg <= idle_cnt_reg + 1'b1;
            else
               stream_cnt_reg <= '0;
         end
      end
   end

   assign engine_run = (stream_cnt_reg == WARM_MAX) && pin_stable_reg[0];

   // ----------------------------------------------------------------------
   // delay adjust
   // ----------------------------------------------------------------------
   logic [rx_train_pkg::TOTAL_W-1:0] total;

   assign total = {delay_out.gross, delay_out.fine};

   // seed while stopped, step while training, hold otherwise
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         delay_out.gross <= rx_train_pkg::GROSS_RST;
         delay_out.fine  <= rx_train_pkg::FINE_RST;
      end
      else if (clk_en_in)
      begin
         if (!train_go_in && seed_load_in)
            delay_out <= seed_in;
         else if (train_go_in && memory_clock_rise_in && engine_run)
         begin
            if (pin_stable_reg[1] && total != '0)
               {delay_out.gross, delay_out.fine} <= total - 1'b1;
            else if (!pin_stable_reg[1] && total != '1)
               {delay_out.gross, delay_out.fine} <= total + 1'b1;
         end
         // no branch while stopped: last values kept
      end
   end

endmodule // phase_recovery_lane

// >>> dv/rx_train_sva.sv
`timescale 1ns/1ps
module rx_train_sva
#(
   parameter int LANES = 9
)
(
   // clock and reset
   input wire logic core_clk_in, rst_n_in,
   // watched inputs
   input wire logic refresh_suppress_in, rx_enable_train_go_in, modecmd_send_in, seed_load_in,
   input wire logic memory_clock_freq_valid_in,
   input wire logic [2:0] memory_clock_freq_select_in,
   input wire rx_train_pkg::mode_cmd_s modecmd_in,
   input wire rx_train_pkg::lane_delay_s [LANES-1:0] seed_in,
   // watched outputs
   input wire logic auto_refresh_enable_out, train_active_out, modecmd_send_out, modecmd_valid_out,
   input wire logic freq_change_pending_out,
   input wire logic [2:0] memory_clock_freq_out,
   input wire rx_train_pkg::mode_cmd_s modecmd_out,
   input wire rx_train_pkg::lane_delay_s [LANES-1:0] recovered_delay_out
);
   // ------
   // properties
   // ------
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   // mirrors follow one cycle late
   refresh_map_a: assert property (auto_refresh_enable_out == !$past(refresh_suppress_in))
      else $error("refresh enable wrong");
   train_mirror_a: assert property (train_active_out == $past(rx_enable_train_go_in))
      else $error("train active wrong");
   // command taken when idle, send and valid end together
   send_take_a: assert property (modecmd_send_in && !modecmd_send_out
      |=> modecmd_send_out && modecmd_out == $past(modecmd_in)) else $error("command not taken");
   send_end_a: assert property ($fell(modecmd_send_out) |-> $fell(modecmd_valid_out))
      else $error("send and valid apart");
   // seed only with training stopped, delays held otherwise
   seed_take_a: assert property (seed_load_in && !rx_enable_train_go_in
      |=> recovered_delay_out == $past(seed_in)) else $error("seed not loaded");
   delay_hold_a: assert property (!seed_load_in && !rx_enable_train_go_in
      |=> $stable(recovered_delay_out)) else $error("delay moved while stopped");
   // frequency applied on valid rise, pending for 40 cycles
   freq_take_a: assert property ($rose(memory_clock_freq_valid_in) && !freq_change_pending_out
      |=> freq_change_pending_out && memory_clock_freq_out == $past(memory_clock_freq_select_in))
      else $error("frequency not applied");
   lock_time_a: assert property ($rose(freq_change_pending_out) |-> freq_change_pending_out[*8]
      ##32 freq_change_pending_out ##1 !freq_change_pending_out) else $error("relock time wrong");
   // main scenarios reached
   cover property ($fell(modecmd_valid_out));
   cover property ($fell(freq_change_pending_out));
   cover property (rx_enable_train_go_in && !$stable(recovered_delay_out));
endmodule // rx_train_sva

// >>> dv/dimm_model.sv
`timescale 1ns/1ps
module dimm_model
(
   // burst request from the bench
   input  wire logic  burst_in,
   // pins towards the phy
   output logic       memory_clock_out,
   output logic [1:0] strobe_out,
   output logic [1:0] late_out
);
   // free-running memory clock, 200 ns period
   initial memory_clock_out = 1'b0;
   always #100 memory_clock_out = ~memory_clock_out;
   // dqs active only while reads stream; lane 0 early, lane 1 late
   initial {strobe_out, late_out} = 4'h0;
   always @(posedge memory_clock_out)
   begin
      strobe_out <= {2{burst_in}};
      late_out   <= burst_in ? 2'h2 : ~late_out; // idle result wobbles
   end
endmodule // dimm_model

// >>> dv/phy_rx_enable_training_bench.sv
`timescale 1ns/1ps
module phy_rx_enable_training_bench;
   // ------
   // signals, design and far side
   // ------
   logic clk = 0, rst_n = 0, sup = 0, dimm = 0, nib = 0, go = 0, send = 0, load = 0;
   logic sr_in = 0, sx_in = 0, fv = 0, burst = 0, mclk;
   logic send_o, valid_o, sre_o, srx_o, sra_o, pend_o, ar_o, zq_o, ta_o, dimm_o, nib_o;
   logic [1:0] zq = 0, strobe, late;
   logic [2:0] fsel = 0, freq_o;
   logic [31:0] rnd_state = 32'h95926f4e;
   rx_train_pkg::mode_cmd_s cmd = '0, cmd_o, cmd_x;
   rx_train_pkg::lane_delay_s [1:0] seed = '0, rec, held;
   int err_count = 0, samples_checked = 0;
   localparam int TARGET_MHZ = 533; // pass-two memory clock
   phy_rx_enable_training #(.LANES(2)) dut
   (
      .core_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(1'b1), .memory_clock_in(mclk),
      .refresh_suppress_in(sup), .zq_short_period_in(zq), .train_target_dimm_in(dimm),
      .train_nibble_select_in(nib), .rx_enable_train_go_in(go), .modecmd_in(cmd),
      .modecmd_send_in(send), .modecmd_send_out(send_o), .modecmd_valid_out(valid_o),
      .modecmd_out(cmd_o), .seed_load_in(load), .seed_in(seed), .dqs_strobe_in(strobe),
      .dqs_late_in(late), .recovered_delay_out(rec), .self_refresh_entry_req_in(sr_in),
      .self_refresh_exit_req_in(sx_in), .memory_clock_freq_valid_in(fv),
      .memory_clock_freq_select_in(fsel), .self_refresh_entry_req_out(sre_o),
      .self_refresh_exit_req_out(srx_o), .self_refresh_active_out(sra_o),
      .freq_change_pending_out(pend_o), .memory_clock_freq_out(freq_o),
      .auto_refresh_enable_out(ar_o), .zq_short_enable_out(zq_o), .train_active_out(ta_o),
      .train_target_dimm_out(dimm_o), .train_nibble_select_out(nib_o)
   );
   dimm_model far (.burst_in(burst), .memory_clock_out(mclk), .strobe_out(strobe), .late_out(late));
   // clock and watchdog
   always #12.5 clk = ~clk;
   initial
   begin
      #150000;
      err_count++;
      tally_and_finish();
   end
   // helpers
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      step(1);
      s = 1'b0;
   endtask
   task automatic check(input string what, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_for(ref logic s, input logic lvl);
      repeat (200) if (s !== lvl) step(1);
      check("wait", s, lvl);
   endtask
   function automatic logic [31:0] rnd();
      rnd_state ^= rnd_state << 13;
      rnd_state ^= rnd_state >> 17;
      rnd_state ^= rnd_state << 5;
      return rnd_state;
   endfunction
   // split a seed total into loaded fine from bits 4:0 and a gross of 1 or 2 from bit 5
   function automatic rx_train_pkg::lane_delay_s seed_of(input logic [7:0] t);
      seed_of.fine = t[4:0];
      seed_of.gross = t[5] ? 3'h1 : 3'h2;
   endfunction
   task automatic tally_and_finish();
      $display("compared %0d mismatched %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // main sequence
   initial
   begin
      step(3);
      check("reset", {ar_o, zq_o, rec, freq_o}, {2'h3, 16'h4040, 3'h0});
      rst_n = 1'b1;
      repeat (20)
      begin
         {sup, zq, dimm, nib} = 5'(rnd());
         step(1);
         check("config", {ar_o, zq_o, dimm_o, nib_o, ta_o}, {!sup, zq != 0, dimm, nib, go});
      end
      sup = 1'b1;
      zq = 2'h0;
      $display("config test done");
      cmd = 22'(rnd());
      pulse(send);
      cmd_x = cmd;
      check("send", send_o, 1);
      cmd = ~cmd;
      step(1);
      pulse(send);
      check("busy", cmd_o, cmd_x);
      wait_for(valid_o, 1);
      wait_for(send_o, 0);
      check("valid", valid_o, 0);
      step(160);
      $display("command test done");
      for (int i = 0; i < 2; i++) seed[i] = seed_of(8'(rnd() & 32'h7f) + 8'h26);
      seed[1] = seed_of(8'h26);
      pulse(load);
      check("seed", rec, seed);
      go = 1'b1;
      repeat (3)
      begin
         burst = 1'b1;
         step(120);
         burst = 1'b0;
         step(100);
      end
      step(1600);
      check("lanes", {rec[0] > seed[0], rec[1] < seed[1]}, 2'h3);
      held = rec;
      seed = ~seed;
      burst = 1'b1;
      pulse(load);
      step(14);
      burst = 1'b0;
      step(40);
      check("gap", rec, held);
      go = 1'b0;
      burst = 1'b1;
      step(200);
      burst = 1'b0;
      check("hold", rec, held);
      $display("training test done");
      pulse(sr_in);
      check("entry", sre_o, 1);
      wait_for(sre_o, 0);
      fsel = 3'(rnd()) | 3'h1;
      fv = 1'b1;
      step(1);
      check("freq", {sra_o, pend_o, freq_o}, {2'h3, fsel});
      pulse(sx_in);
      check("early exit", srx_o, 0);
      wait_for(pend_o, 0);
      pulse(sx_in);
      check("exit", srx_o, 1);
      wait_for(srx_o, 0);
      check("running", sra_o, 0);
      $display("frequency test done");
      cmd = 22'(rnd());
      pulse(send);
      wait_for(send_o, 0);
      check("latency cmd", cmd_o, cmd);
      seed[0] = seed_of(8'(int'(held[0]) * TARGET_MHZ / 400));
      pulse(load);
      check("seed two", rec, seed);
      step(160);
      sup = 1'b0;
      zq = 2'h1;
      step(1);
      check("restore", {ar_o, zq_o}, 2'h3);
      $display("pass two test done");
      tally_and_finish();
   end
endmodule // phy_rx_enable_training_bench

bind phy_rx_enable_training rx_train_sva #(.LANES(LANES)) chk (.*);
